// ---- design/panel_ctrl_pkg.sv ----
// Constants for the panel power, gray offset and retrace line clock block.
// Assumes a 20 MHz core clock and an indexed register port (index + data).
package panel_ctrl_pkg;

  // ****************************************************************
  // Register indices and fields
  // ****************************************************************
  localparam logic [7:0] gray_power_index = 8'hd6;
  localparam logic [7:0] retrace_count_index = 8'hd7;
  localparam int gray_offset_bit = 0;
  localparam int seq_ctrl_bit = 1;
  localparam int seq_time_bit = 2;
  localparam logic [7:0] gray_power_mask = 8'hf7; // Bit 3 reserved
  localparam logic [7:0] retrace_count_mask = 8'h1f; // Bits 7:5 reserved
  localparam logic [7:0] gray_power_reset = 8'h00;
  localparam logic [7:0] retrace_count_reset = 8'h00;

  // ****************************************************************
  // Gray offset values
  // ****************************************************************
  localparam logic [3:0] gray_offset_normal = 4'hd; // 13
  localparam logic [3:0] gray_offset_low_flicker = 4'h4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint clock_hz = 20000000;
  localparam longint step_long_ms = 128; // 128-136 ms window
  localparam longint step_short_ms = 32; // 32-40 ms window
  localparam longint step_long_cycles = step_long_ms * clock_hz / 1000;
  localparam longint step_short_cycles = step_short_ms * clock_hz / 1000;
  localparam int step_width = 22;
  // Extra line clocks: period and high width in core cycles
  localparam logic [3:0] extra_period = 4'h4;
  localparam logic [3:0] extra_high = 4'h1;
  localparam int power_steps = 3;

  // ****************************************************************
  // Power sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    pwr_off = 2'b00,
    pwr_up = 2'b01,
    pwr_on = 2'b10,
    pwr_down = 2'b11
  } pwr_state_t;

endpackage

// ---- design/panel_power_retrace_control.sv ----
// Panel power sequencing, gray offset select and retrace line clocks.
// Assumes register writes come over an index/data port on the core clock,
// frame_gap marks vertical retrace and power_good_in is an async pin.
`timescale 1ns/1ps
`default_nettype none
module panel_power_retrace_control
  import panel_ctrl_pkg::*;
#(
  parameter longint step_long = step_long_cycles,
  parameter longint step_short = step_short_cycles
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Indexed register port
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  output logic [7:0] reg_rdata,
  // Panel timing
  input wire logic frame_gap,
  input wire logic normal_line_clock,
  output logic panel_line_clock,
  // Power
  input wire logic power_good_in,
  output logic [panel_ctrl_pkg::power_steps-1:0] panel_power_en,
  output logic panel_powered,
  // Grayscale
  output logic [3:0] gray_offset
);
  import panel_ctrl_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] gray_power_q;
  logic [7:0] retrace_q;

  // Register writes, reserved bits held at zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gray_power_q <= gray_power_reset;
      retrace_q <= retrace_count_reset;
    end else if (clk_en && reg_write) begin
      if (reg_index == gray_power_index) begin
        gray_power_q <= reg_wdata & gray_power_mask;
      end
      if (reg_index == retrace_count_index) begin
        retrace_q <= reg_wdata & retrace_count_mask;
      end
    end
  end

  // Read data mux, unmapped index reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_index == gray_power_index) begin
        reg_rdata <= gray_power_q;
      end else if (reg_index == retrace_count_index) begin
        reg_rdata <= retrace_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gray_offset <= gray_offset_normal;
    end else if (clk_en) begin
      gray_offset <= gray_power_q[gray_offset_bit] ?
                     gray_offset_low_flicker : gray_offset_normal;
    end
  end

  // ****************************************************************
  // Power good synchroniser
  // ****************************************************************
  logic pg_meta_q;
  logic pg_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pg_meta_q <= 1'b0;
      pg_q <= 1'b0;
    end else if (clk_en) begin
      pg_meta_q <= power_good_in;
      pg_q <= pg_meta_q;
    end
  end

  // ****************************************************************
  // Power sequencer
  // ****************************************************************
  pwr_state_t state_q;
  logic [1:0] step_q;
  logic timer_load;
  logic timer_busy_q;
  logic timer_done;
  logic [21:0] step_count;
  logic seq_bit;

  assign seq_bit = gray_power_q[seq_ctrl_bit];
  assign step_count = gray_power_q[seq_time_bit] ?
                      step_long[21:0] : step_short[21:0];

  // timer start gated by power good
  assign timer_load = !timer_busy_q && pg_q &&
                      ((state_q == pwr_up) || (state_q == pwr_down));

  step_timer u_step_timer (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(timer_load),
    .count_in(step_count),
    .expired(timer_done)
  );

  // Timer busy flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_busy_q <= 1'b0;
    end else if (clk_en) begin
      if (timer_load) begin
        timer_busy_q <= 1'b1;
      end else if (timer_done) begin
        timer_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pwr_off;
      step_q <= 2'b00;
    end else if (clk_en) begin
      unique case (state_q)
        pwr_off: begin
          if (seq_bit) begin
            state_q <= pwr_up;
          end
        end
        pwr_up: begin
          // no step taken yet, so reversing drops straight to off
          if (!seq_bit && step_q == 2'b00) begin
            state_q <= pwr_off;
          end else if (!seq_bit) begin
            state_q <= pwr_down;
          end else if (timer_done) begin
            if (step_q == 2'(power_steps - 1)) begin
              state_q <= pwr_on;
            end
            step_q <= step_q + 2'b01;
          end
        end
        pwr_on: begin
          if (!seq_bit) begin
            state_q <= pwr_down;
          end
        end
        pwr_down: begin
          // reversing before the first step down returns to on
          if (seq_bit && step_q == 2'(power_steps)) begin
            state_q <= pwr_on;
          end else if (seq_bit) begin
            state_q <= pwr_up;
          end else if (timer_done) begin
            if (step_q == 2'b01) begin
              state_q <= pwr_off;
            end
            step_q <= step_q - 2'b01;
          end
        end
      endcase
    end
  end

  // Power enables follow the step count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      panel_power_en <= '0;
      panel_powered <= 1'b0;
    end else if (clk_en) begin
      for (int i = 0; i < power_steps; i++) begin
        panel_power_en[i] <= (step_q > 2'(i));
      end
      panel_powered <= (state_q == pwr_on);
    end
  end

  // ****************************************************************
  // Retrace extra line clocks
  // ****************************************************************
  logic gap_q;
  logic [5:0] extra_left_q;
  logic [3:0] phase_q;

  // load count plus one at start of gap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 1'b0;
      extra_left_q <= 6'h00;
      phase_q <= 4'h0;
    end else if (clk_en) begin
      gap_q <= frame_gap;
      if (frame_gap && !gap_q) begin
        extra_left_q <= {1'b0, retrace_q[4:0]} + 6'h01;
        phase_q <= 4'h0;
      end else if (!frame_gap) begin
        extra_left_q <= 6'h00;
      end else if (extra_left_q != 6'h00) begin
        if (phase_q == extra_period - 4'h1) begin
          phase_q <= 4'h0;
          extra_left_q <= extra_left_q - 6'h01;
        end else begin
          phase_q <= phase_q + 4'h1;
        end
      end
    end
  end

  // fast narrow pulses in gap, normal clock otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      panel_line_clock <= 1'b0;
    end else if (clk_en) begin
      if (frame_gap && gap_q && extra_left_q != 6'h00) begin
        panel_line_clock <= (phase_q < extra_high);
      end else if (frame_gap) begin
        panel_line_clock <= 1'b0;
      end else begin
        panel_line_clock <= normal_line_clock;
      end
    end
  end

endmodule
`default_nettype wire

// ---- design/step_timer.sv ----
// Down-counting step timer for the power sequencer.
// Assumes the caller holds load for one cycle to start a step.
`timescale 1ns/1ps
`default_nettype none
module step_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Control
  input wire logic load,
  input wire logic [21:0] count_in,
  // Status
  output logic expired
);

  logic [21:0] cnt_q;

  // Count down to zero, one pulse on reaching it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 22'h000000;
      expired <= 1'b0;
    end else if (clk_en) begin
      expired <= 1'b0;
      if (load) begin
        cnt_q <= count_in;
      end else if (cnt_q != 22'h000000) begin
        cnt_q <= cnt_q - 22'h000001;
        expired <= (cnt_q == 22'h000001);
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/panel_ctrl_chk.sv ----
// Port checker for the panel control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module panel_ctrl_chk
  import panel_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [7:0] reg_rdata,
  // Panel side
  input wire logic frame_gap,
  input wire logic normal_line_clock,
  input wire logic panel_line_clock,
  input wire logic [panel_ctrl_pkg::power_steps-1:0] panel_power_en,
  input wire logic panel_powered,
  input wire logic [3:0] gray_offset
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ****
  // Sequences
  // ****
  sequence s_wr(idx);
    clk_en && reg_write && reg_index == idx ##1 clk_en;
  endsequence
  sequence s_gap_on;
    clk_en && $rose(frame_gap) ##1 clk_en && frame_gap;
  endsequence
  property p_gray;
    s_wr(8'hd6) |=> gray_offset == ($past(reg_wdata[0], 2) ? 4'h4 : 4'hd);
  endproperty
  a_gray: assert property (p_gray) else $error("gray offset wrong");
  property p_field;
    s_wr(8'hd7) ##0 reg_index == 8'hd7
      |=> reg_rdata == {3'h0, $past(reg_wdata[4:0], 2)};
  endproperty
  a_field: assert property (p_field) else $error("count field wrong");
  property p_unmapped;
    $past(clk_en) && !($past(reg_index) inside {8'hd6, 8'hd7})
      |-> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_reserved;
    $past(clk_en) && $past(reg_index) == 8'hd7 |-> reg_rdata[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits");
  property p_normal;
    $past(clk_en) && !frame_gap && !$past(frame_gap) && !$past(frame_gap, 2)
      && !$past(frame_gap, 3) |-> panel_line_clock == $past(normal_line_clock);
  endproperty
  a_normal: assert property (p_normal) else $error("normal clock");
  property p_first;
    s_gap_on |=> panel_line_clock;
  endproperty
  a_first: assert property (p_first) else $error("no first pulse");
  property p_width;
    clk_en && frame_gap && $past(frame_gap, 2) && panel_line_clock
      ##1 frame_gap |-> !panel_line_clock;
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_steps;
    panel_power_en inside {3'b000, 3'b001, 3'b011, 3'b111};
  endproperty
  a_steps: assert property (p_steps) else $error("enable order");
  property p_on;
    panel_powered |-> panel_power_en == 3'b111;
  endproperty
  a_on: assert property (p_on) else $error("powered early");
endmodule
bind panel_power_retrace_control panel_ctrl_chk u_chk (.*);
`default_nettype wire

// ---- tb/panel_supply_model.sv ----
// Panel supply and line clock counter at the far side.
// Assumes the same core clock as the block.
`timescale 1ns/1ps
`default_nettype none
module panel_supply_model (
  // Clock and supply state
  input wire logic clock,
  input wire logic supply_ok,
  // Panel timing in
  input wire logic frame_gap,
  input wire logic panel_line_clock,
  // Results
  output logic power_good_in,
  output int line_pulses
);
  logic line_q = 1'b0;
  // Power good tracks the supply
  always_ff @(posedge clock) begin
    power_good_in <= supply_ok;
  end
  // Count line clock pulses inside the gap
  always_ff @(posedge clock) begin
    line_q <= panel_line_clock;
    if (frame_gap && panel_line_clock && !line_q) begin
      line_pulses <= line_pulses + 1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_panel_power_retrace_control.sv ----
// Bench for the panel control block with a register model.
// Assumes short step parameters of 20 and 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_panel_power_retrace_control;
  import panel_ctrl_pkg::*;
  logic clock = 0, rst_n = 0, clk_en = 1, reg_write = 0, frame_gap = 0;
  logic normal_line_clock = 0, supply_ok = 1, run_norm = 0;
  logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic panel_line_clock, power_good_in, panel_powered;
  logic [2:0] panel_power_en;
  logic [3:0] gray_offset;
  int fails = 0, n_compared = 0, seed = 67046, line_pulses, k, h, nc = 0;
  int mdl [2];
  panel_power_retrace_control #(.step_long(20), .step_short(8)) u_dut (.*);
  panel_supply_model u_sup (.*);
  always #25 clock = ~clock;
  // Normal line clock, 16 cycle period
  always @(negedge clock) begin
    nc <= nc + 1;
    normal_line_clock <= run_norm && nc[3];
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] i, logic [7:0] d);
    @(negedge clock);
    reg_index = i;
    reg_wdata = d;
    reg_write = 1;
    @(negedge clock);
    reg_write = 0;
    // Writes are dropped while the clock enable is low
    if (clk_en && i inside {8'hd6, 8'hd7})
      mdl[i[0]] = d & (i[0] ? 8'h1f : 8'hf7);
  endtask
  task automatic rd(logic [7:0] i);
    @(negedge clock);
    reg_index = i;
    repeat (2) @(negedge clock);
    chk("rdata", (i inside {8'hd6, 8'hd7}) ? 8'(mdl[i[0]]) : 8'h00, reg_rdata);
  endtask
  task automatic wait_pw(logic [2:0] e, int lo, int hi);
    k = 0;
    while (panel_power_en !== e && k < hi) begin
      @(negedge clock);
      k++;
    end
    chk("enables", {5'h0, e}, {5'h0, panel_power_en});
    chk("step time", 8'h01, {7'h0, k >= lo});
  endtask
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(50 * 8000);
    fails++;
    complete_run;
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1;
    repeat (40) @(negedge clock);
    chk("gray", 8'h0d, {4'h0, gray_offset});
    chk("off", 8'h00, {5'h0, panel_power_en});
    rd(8'hd6);
    rd(8'hd7);
    for (int b = 0; b < 2; b++) begin
      v = $random(seed);
      wr(8'hd6, (v & 8'hf8) | 8'(b));
      @(negedge clock);
      chk("gray", b ? 8'h04 : 8'h0d, {4'h0, gray_offset});
      rd(8'hd6);
    end
    wr(8'hd5, 8'hff);
    rd(8'hd5);
    // Clock enable low freezes registers and outputs
    clk_en = 0;
    wr(8'hd6, 8'h00);
    @(negedge clock);
    chk("frozen", mdl[0][0] ? 8'h04 : 8'h0d, {4'h0, gray_offset});
    clk_en = 1;
    rd(8'hd6);
    $display("done registers");
    foreach (mdl[j]) begin
      v = (j == 0) ? 8'h00 : 8'hff;
      repeat (2) begin
        wr(8'hd7, v);
        rd(8'hd7);
        k = line_pulses;
        h = 0;
        frame_gap = 1;
        repeat (4 * (v[4:0] + 1) + 8) begin
          @(negedge clock);
          h += panel_line_clock;
        end
        frame_gap = 0;
        chk("extra", 8'(v[4:0] + 1), 8'(line_pulses - k));
        chk("high", 8'(v[4:0] + 1), 8'(h));
        v = $random(seed);
      end
    end
    $display("done retrace");
    run_norm = 1;
    supply_ok = 0;
    wr(8'hd6, 8'h02);
    repeat (60) @(negedge clock);
    chk("stalled", 8'h00, {5'h0, panel_power_en});
    supply_ok = 1;
    wait_pw(3'b111, 21, 80);
    chk("powered", 8'h01, {7'h0, panel_powered});
    wr(8'hd6, 8'h04);
    wait_pw(3'b000, 57, 72);
    chk("unpowered", 8'h00, {7'h0, panel_powered});
    // Reverse inside the first step: nothing may switch on
    wr(8'hd6, 8'h02);
    wr(8'hd6, 8'h00);
    repeat (30) @(negedge clock);
    chk("aborted", 8'h00, {5'h0, panel_power_en});
    wr(8'hd6, 8'h06);
    wait_pw(3'b111, 57, 72);
    $display("done power");
    complete_run;
  end
endmodule
`default_nettype wire
